// *** common/drive_ctrl_defs.vh ***
// constants for the drive device-control state machine
`ifndef DRIVE_CTRL_DEFS_VH
`define DRIVE_CTRL_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define REG_CTRL_WORD   4'h0
`define REG_STATUS_WORD 4'h4
`define REG_QS_OPTION   4'h8
`define REG_STATE       4'hC

// ****************************************
// control word bits
// ****************************************
`define CW_SWITCH_ON   0
`define CW_ENABLE_VOLT 1
`define CW_QUICK_STOP  2
`define CW_ENABLE_OP   3
`define CW_FAULT_RESET 7

// ****************************************
// status word bits
// ****************************************
`define SW_READY     0
`define SW_SWITCHED  1
`define SW_OP_EN     2
`define SW_FAULT     3
`define SW_VOLT_EN   4
`define SW_QUICKSTOP 5
`define SW_SO_DIS    6
`define SW_REMOTE    9

// ****************************************
// states
// ****************************************
`define ST_NOT_READY  3'h0
`define ST_SO_DIS     3'h1
`define ST_READY      3'h2
`define ST_SWITCHED   3'h3
`define ST_OP_EN      3'h4
`define ST_QS_ACTIVE  3'h5
`define ST_FAULT_REAC 3'h6
`define ST_FAULT      3'h7

// ****************************************
// misc values
// ****************************************
`define QS_OPT_STAY   16'h0005
`define QS_OPT_RESET  16'h0000
`define CTRL_RESET    16'h0000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** design/control_word_decoder.v ***
// decodes device-control commands from the control word
`timescale 1ns/100ps
`default_nettype none
`include "drive_ctrl_defs.vh"
module control_word_decoder (
    // control word in
    input  wire [15:0] ctrlWord,
    // decoded commands
    output wire        cmdShutdown,
    output wire        cmdSwitchOn,
    output wire        cmdDisableVolt,
    output wire        cmdQuickStop,
    output wire        cmdDisableOp,
    output wire        cmdEnableOp,
    output wire        cmdFaultReset
);
    wire so;
    wire ev;
    wire qs;
    wire eo;
    wire fr;

    assign so = ctrlWord[`CW_SWITCH_ON];
    assign ev = ctrlWord[`CW_ENABLE_VOLT];
    assign qs = ctrlWord[`CW_QUICK_STOP];
    assign eo = ctrlWord[`CW_ENABLE_OP];
    assign fr = ctrlWord[`CW_FAULT_RESET];

    // quick stop bit is active low
    assign cmdShutdown    = ~fr & qs & ev & ~so;
    assign cmdSwitchOn    = ~fr & qs & ev & so;
    assign cmdDisableVolt = ~fr & ~ev;
    assign cmdQuickStop   = ~fr & ~qs & ev;
    assign cmdDisableOp   = ~fr & ~eo & qs & ev & so;
    assign cmdEnableOp    = ~fr & eo & qs & ev & so;
    assign cmdFaultReset  = fr;
endmodule
`default_nettype wire

// *** design/drive_device_control_fsm.v ***
// drive device-control state machine with an AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "drive_ctrl_defs.vh"
module drive_device_control_fsm (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [3:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [3:0]  s_axi_araddr,
    // AXI4-Lite read data
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    // internal drive events
    input  wire        selfTestDone,
    input  wire        selfTestOk,
    input  wire        faultActive,
    input  wire        faultReactionDone,
    input  wire        quickStopDone,
    input  wire        motionReq,
    // drive control outputs
    output wire        powerOn,
    output wire        driveEnable,
    output wire        brakeApply,
    output wire        commActive,
    output wire        quickStopRun,
    output wire        motionAccept,
    output wire [15:0] statusWord
);

    // ****************************************
    // register state
    // ****************************************
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [15:0] ctrlWord_reg;
    reg [15:0] qsOption_reg;
    reg        faultResetPrev_reg;
    reg [15:0] status_reg;
    reg [15:0] status_next;
    reg        powerOn_reg;
    reg        driveEnable_reg;
    reg        brakeApply_reg;
    reg        commActive_reg;
    reg        quickStopRun_reg;
    reg        motionAccept_reg;

    // ****************************************
    // bus state
    // ****************************************
    reg        awReady_reg;
    reg [3:0]  awAddr_reg;
    reg        wReady_reg;
    reg [31:0] wData_reg;
    reg [3:0]  wStrb_reg;
    reg        bValid_reg;
    reg [1:0]  bResp_reg;
    reg        rValid_reg;
    reg        arReady_reg;
    reg [31:0] rData_reg;
    reg [1:0]  rResp_reg;

    wire cmdShutdown;
    wire cmdSwitchOn;
    wire cmdDisableVolt;
    wire cmdQuickStop;
    wire cmdDisableOp;
    wire cmdEnableOp;
    wire cmdFaultReset;
    wire faultResetEdge;
    wire qsStay;
    wire writeGo;
    wire readGo;
    wire wrCtrl;
    wire wrQsOpt;
    wire wrMapped;

    control_word_decoder decoder (
        .ctrlWord       (ctrlWord_reg),
        .cmdShutdown    (cmdShutdown),
        .cmdSwitchOn    (cmdSwitchOn),
        .cmdDisableVolt (cmdDisableVolt),
        .cmdQuickStop   (cmdQuickStop),
        .cmdDisableOp   (cmdDisableOp),
        .cmdEnableOp    (cmdEnableOp),
        .cmdFaultReset  (cmdFaultReset)
    );

    // fault reset acts on the rising edge so a bit left high cannot re-fire
    assign faultResetEdge = cmdFaultReset & ~faultResetPrev_reg;
    assign qsStay = (qsOption_reg == `QS_OPT_STAY);

    // ****************************************
    // state transitions
    // ****************************************
    always @* begin
        state_next = state_reg;
        // internal faults are checked before any host command
        if (faultActive && state_reg != `ST_FAULT_REAC && state_reg != `ST_FAULT) begin
            state_next = `ST_FAULT_REAC;
        end else begin
            case (state_reg)
                `ST_NOT_READY: begin
                    // a failed self-test is handled as a fault
                    if (selfTestDone && selfTestOk) begin
                        state_next = `ST_SO_DIS;
                    end else if (selfTestDone) begin
                        state_next = `ST_FAULT_REAC;
                    end
                end
                `ST_SO_DIS: begin
                    if (cmdShutdown) begin
                        state_next = `ST_READY;
                    end
                end
                `ST_READY: begin
                    if (cmdDisableVolt || cmdQuickStop) begin
                        state_next = `ST_SO_DIS;
                    end else if (cmdSwitchOn) begin
                        state_next = `ST_SWITCHED;
                    end
                end
                `ST_SWITCHED: begin
                    if (cmdDisableVolt || cmdQuickStop) begin
                        state_next = `ST_SO_DIS;
                    end else if (cmdShutdown) begin
                        state_next = `ST_READY;
                    end else if (cmdEnableOp) begin
                        state_next = `ST_OP_EN;
                    end
                end
                `ST_OP_EN: begin
                    if (cmdDisableVolt) begin
                        state_next = `ST_SO_DIS;
                    end else if (cmdQuickStop) begin
                        state_next = `ST_QS_ACTIVE;
                    end else if (cmdShutdown) begin
                        state_next = `ST_READY;
                    end else if (cmdDisableOp) begin
                        state_next = `ST_SWITCHED;
                    end
                end
                `ST_QS_ACTIVE: begin
                    if (qsStay) begin
                        if (cmdEnableOp) begin
                            state_next = `ST_OP_EN;
                        end
                    end else if (quickStopDone || cmdDisableVolt) begin
                        state_next = `ST_SO_DIS;
                    end
                end
                `ST_FAULT_REAC: begin
                    if (faultReactionDone) begin
                        state_next = `ST_FAULT;
                    end
                end
                `ST_FAULT: begin
                    if (faultResetEdge && !faultActive) begin
                        state_next = `ST_SO_DIS;
                    end
                end
                default: begin
                    state_next = `ST_NOT_READY;
                end
            endcase
            // anything not matched above leaves the state unchanged
        end
    end

    // ****************************************
    // status word
    // ****************************************
    always @* begin
        status_next = 16'h0000;
        status_next[`SW_REMOTE] = 1'b1;
        case (state_next)
            `ST_NOT_READY: begin
                status_next[`SW_QUICKSTOP] = 1'b0;
            end
            `ST_SO_DIS: begin
                status_next[`SW_SO_DIS] = 1'b1;
            end
            `ST_READY: begin
                status_next[`SW_READY] = 1'b1;
                status_next[`SW_QUICKSTOP] = 1'b1;
            end
            `ST_SWITCHED: begin
                status_next[`SW_READY] = 1'b1;
                status_next[`SW_SWITCHED] = 1'b1;
                status_next[`SW_QUICKSTOP] = 1'b1;
                status_next[`SW_VOLT_EN] = 1'b1;
            end
            `ST_OP_EN: begin
                status_next[`SW_READY] = 1'b1;
                status_next[`SW_SWITCHED] = 1'b1;
                status_next[`SW_OP_EN] = 1'b1;
                status_next[`SW_QUICKSTOP] = 1'b1;
                status_next[`SW_VOLT_EN] = 1'b1;
            end
            `ST_QS_ACTIVE: begin
                // quick stop bit low marks the stop in progress
                status_next[`SW_READY] = 1'b1;
                status_next[`SW_SWITCHED] = 1'b1;
                status_next[`SW_OP_EN] = 1'b1;
                status_next[`SW_VOLT_EN] = 1'b1;
            end
            `ST_FAULT_REAC: begin
                status_next[`SW_READY] = 1'b1;
                status_next[`SW_SWITCHED] = 1'b1;
                status_next[`SW_OP_EN] = 1'b1;
                status_next[`SW_FAULT] = 1'b1;
                status_next[`SW_VOLT_EN] = 1'b1;
            end
            `ST_FAULT: begin
                status_next[`SW_FAULT] = 1'b1;
            end
            default: begin
                status_next[`SW_FAULT] = 1'b0;
            end
        endcase
    end

    // ****************************************
    // state and drive outputs
    // ****************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg          <= `ST_NOT_READY;
            faultResetPrev_reg <= 1'b0;
            status_reg         <= 16'h0200;
            powerOn_reg        <= 1'b0;
            driveEnable_reg    <= 1'b0;
            brakeApply_reg     <= 1'b1;
            commActive_reg     <= 1'b0;
            quickStopRun_reg   <= 1'b0;
            motionAccept_reg   <= 1'b0;
        end else begin
            state_reg          <= state_next;
            faultResetPrev_reg <= cmdFaultReset;
            status_reg         <= status_next;
            // power is cut in the same cycle the state leaves the powered set
            powerOn_reg <= (state_next == `ST_SWITCHED) || (state_next == `ST_OP_EN) ||
                           (state_next == `ST_QS_ACTIVE) || (state_next == `ST_FAULT_REAC);
            driveEnable_reg <= (state_next == `ST_OP_EN) || (state_next == `ST_QS_ACTIVE) ||
                               (state_next == `ST_FAULT_REAC);
            brakeApply_reg <= !((state_next == `ST_OP_EN) || (state_next == `ST_QS_ACTIVE) ||
                                (state_next == `ST_FAULT_REAC));
            commActive_reg <= (state_next != `ST_NOT_READY);
            quickStopRun_reg <= (state_next == `ST_QS_ACTIVE) || (state_next == `ST_FAULT_REAC);
            motionAccept_reg <= motionReq && (state_reg == `ST_OP_EN) &&
                                (state_next == `ST_OP_EN);
        end
    end

    // ****************************************
    // bus write channel
    // ****************************************
    assign writeGo  = !awReady_reg && !wReady_reg && !bValid_reg;
    assign wrCtrl   = writeGo && (awAddr_reg == `REG_CTRL_WORD);
    assign wrQsOpt  = writeGo && (awAddr_reg == `REG_QS_OPTION);
    assign wrMapped = (awAddr_reg == `REG_CTRL_WORD) || (awAddr_reg == `REG_QS_OPTION);

    always @(posedge sys_clk) begin
        if (rst) begin
            awReady_reg <= 1'b1;
            awAddr_reg  <= 4'h0;
            wReady_reg  <= 1'b1;
            wData_reg  <= 32'h00000000;
            wStrb_reg  <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awReady_reg) begin
                awReady_reg <= 1'b0;
                awAddr_reg <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (s_axi_wvalid && wReady_reg) begin
                wReady_reg <= 1'b0;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (writeGo) begin
                bValid_reg <= 1'b1;
                bResp_reg  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bValid_reg && s_axi_bready) begin
                bValid_reg  <= 1'b0;
                awReady_reg <= 1'b1;
                wReady_reg  <= 1'b1;
            end
        end
    end

    // ****************************************
    // writable registers
    // ****************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrlWord_reg <= `CTRL_RESET;
            qsOption_reg <= `QS_OPT_RESET;
        end else begin
            // commands are only taken once communication is active
            if (wrCtrl && commActive_reg) begin
                if (wStrb_reg[0]) begin
                    ctrlWord_reg[7:0] <= wData_reg[7:0];
                end
                if (wStrb_reg[1]) begin
                    ctrlWord_reg[15:8] <= wData_reg[15:8];
                end
            end
            // parameters stay writable in every state
            if (wrQsOpt) begin
                if (wStrb_reg[0]) begin
                    qsOption_reg[7:0] <= wData_reg[7:0];
                end
                if (wStrb_reg[1]) begin
                    qsOption_reg[15:8] <= wData_reg[15:8];
                end
            end
        end
    end

    // ****************************************
    // bus read channel
    // ****************************************
    assign readGo = s_axi_arvalid && !rValid_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            rValid_reg  <= 1'b0;
            arReady_reg <= 1'b1;
            rData_reg   <= 32'h00000000;
            rResp_reg  <= `RESP_OKAY;
        end else if (readGo) begin
            rValid_reg  <= 1'b1;
            arReady_reg <= 1'b0;
            rResp_reg  <= `RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'h0})
                `REG_CTRL_WORD: begin
                    rData_reg <= {16'h0000, ctrlWord_reg};
                end
                `REG_STATUS_WORD: begin
                    rData_reg <= {16'h0000, status_reg};
                end
                `REG_QS_OPTION: begin
                    rData_reg <= {16'h0000, qsOption_reg};
                end
                `REG_STATE: begin
                    rData_reg <= {29'h0000000, state_reg};
                end
                default: begin
                    rData_reg <= 32'h00000000;
                    rResp_reg <= `RESP_SLVERR;
                end
            endcase
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg  <= 1'b0;
            arReady_reg <= 1'b1;
        end
    end

    // ****************************************
    // output wiring
    // ****************************************
    assign s_axi_awready = awReady_reg;
    assign s_axi_wready  = wReady_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;
    assign powerOn       = powerOn_reg;
    assign driveEnable   = driveEnable_reg;
    assign brakeApply    = brakeApply_reg;
    assign commActive    = commActive_reg;
    assign quickStopRun  = quickStopRun_reg;
    assign motionAccept  = motionAccept_reg;
    assign statusWord    = status_reg;
endmodule
`default_nettype wire

// *** dv/drive_ctrl_asserts.sv ***
// assertions on the ports of the drive device-control state machine
`timescale 1ns/100ps
`default_nettype none
module drive_ctrl_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // drive events
    input wire logic        selfTestDone,
    input wire logic        selfTestOk,
    input wire logic        faultActive,
    input wire logic        faultReactionDone,
    input wire logic        motionReq,
    // drive outputs
    input wire logic        powerOn,
    input wire logic        driveEnable,
    input wire logic        brakeApply,
    input wire logic        commActive,
    input wire logic        quickStopRun,
    input wire logic        motionAccept,
    input wire logic [15:0] statusWord
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ****************
    // fault steps
    // ****************
    sequence s_fault_seen;
        faultActive && !statusWord[3];
    endsequence
    sequence s_reaction_end;
        statusWord == 16'h021F && faultReactionDone;
    endsequence
    a_fault_wins: assert property (s_fault_seen |=> statusWord == 16'h021F) else $error("fault not taken");
    a_fault_settles: assert property (s_reaction_end |=> statusWord == 16'h0208 && !driveEnable) else $error("no fault state");
    a_test_pass: assert property (statusWord == 16'h0200 && selfTestDone && selfTestOk && !faultActive
        |=> statusWord == 16'h0240 && commActive) else $error("self test exit wrong");
    a_notready_safe: assert property (statusWord == 16'h0200 |-> brakeApply && !driveEnable) else $error("unsafe");
    a_remote_set: assert property (statusWord[9]) else $error("remote bit low");
    a_motion_gate: assert property (motionAccept |-> $past(motionReq) && $past(statusWord) == 16'h0237
        && statusWord == 16'h0237) else $error("motion outside enabled");
    a_drive_state: assert property (driveEnable == statusWord[2]) else $error("drive enable wrong");
    a_power_state: assert property (powerOn == statusWord[1]) else $error("power wrong");
    a_qs_run: assert property (quickStopRun == (statusWord[2] && !statusWord[5])) else $error("stop run wrong");
endmodule
bind drive_device_control_fsm drive_ctrl_checker u_checker (
    .sys_clk, .rst, .selfTestDone, .selfTestOk, .faultActive, .faultReactionDone, .motionReq,
    .powerOn, .driveEnable, .brakeApply, .commActive, .quickStopRun, .motionAccept, .statusWord
);
`default_nettype wire

// *** dv/host_master_model.sv ***
// host side register master speaking AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module host_master_model (
    // clock
    input  wire logic        sys_clk,
    // write channels
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [3:0]       s_axi_awaddr,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    // read channels
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    output logic [3:0]       s_axi_araddr,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp
);
    // ready lines stay high so no strobe is ever assigned twice in one step
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
        s_axi_wdata = 32'h00000000;
    end
    task automatic write_reg(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aDone;
        logic wDone;
        aDone = 1'b0;
        wDone = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aDone && wDone)) begin
            @(posedge sys_clk);
            if (!aDone && s_axi_awready) begin
                aDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic read_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

// *** dv/test_drive_device_control_fsm.sv ***
// self-checking bench for the drive device-control state machine
`timescale 1ns/100ps
`default_nettype none
`include "drive_ctrl_defs.vh"
module test_drive_device_control_fsm;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        selfTestOk = 1'b1;
    logic        faultActive = 1'b0;
    // one-cycle events: 0 self-test done, 1 reaction done, 2 quick stop done, 3 motion request
    logic [3:0]  events = 4'h0;
    wire         selfTestDone = events[0];
    wire         faultReactionDone = events[1];
    wire         quickStopDone = events[2];
    wire         motionReq = events[3];
    wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [3:0]   s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    wire [31:0]  s_axi_wdata, s_axi_rdata;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire         powerOn, driveEnable, brakeApply, commActive, quickStopRun, motionAccept;
    wire [15:0]  statusWord;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    // upper half: command written, lower half: status word expected after it
    logic [31:0] seqTab [32] = '{32'h0006_0221, 32'h0002_0240, 32'h0006_0221, 32'h0007_0233, 32'h0002_0240,
        32'h000F_0240, 32'h0006_0221, 32'h0007_0233, 32'h0000_0240, 32'h0006_0221, 32'h0007_0233,
        32'h000F_0237, 32'h0007_0233, 32'h0006_0221, 32'h0000_0240, 32'h0006_0221, 32'h0007_0233,
        32'h000F_0237, 32'h0006_0221, 32'h0007_0233, 32'h000F_0237, 32'h0000_0240, 32'h0006_0221,
        32'h0007_0233, 32'h000F_0237, 32'h0002_0217, 32'h0006_0221, 32'h0007_0233, 32'h000F_0237,
        32'h0002_0217, 32'h0000_0217, 32'h000F_0237};
    host_master_model u_host (.sys_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    drive_device_control_fsm u_dut (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .selfTestDone, .selfTestOk, .faultActive, .faultReactionDone, .quickStopDone, .motionReq,
        .powerOn, .driveEnable, .brakeApply, .commActive, .quickStopRun, .motionAccept, .statusWord);
    always #10 sys_clk = ~sys_clk;
    // ****************
    // helpers
    // ****************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic pulse(input logic [3:0] sel);
        @(posedge sys_clk);
        events <= sel;
        @(posedge sys_clk);
        events <= 4'h0;
        #1;
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic step(input int lo, input int hi);
        for (int i = lo; i < hi; i++) begin
            u_host.write_reg(`REG_CTRL_WORD, {16'h0000, seqTab[i][31:16]}, rs);
            settle();
            check("statusWord", statusWord, seqTab[i][15:0]);
            check("powerOn", powerOn, seqTab[i][1]);
            u_host.read_reg(`REG_STATUS_WORD, rd, rs);
            check("statusReg", rd, {16'h0000, seqTab[i][15:0]});
        end
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        check("brakeApply", brakeApply, 1'b1);
        check("commActive", commActive, 1'b0);
        u_host.write_reg(`REG_CTRL_WORD, 32'h0000_0006, rs);
        settle();
        check("statusWord", statusWord, 16'h0200);
        u_host.read_reg(`REG_QS_OPTION, rd, rs);
        check("qsOption", rd, 32'h0000_0000);
        u_host.write_reg(`REG_STATUS_WORD, 32'h0000_FFFF, rs);
        check("roWrite", rs, `RESP_SLVERR);
        pulse(4'h1);
        check("statusWord", statusWord, 16'h0240);
        check("commActive", commActive, 1'b1);
        pulse(4'h8);
        check("motionAccept", motionAccept, 1'b0);
        step(0, 26);
        pulse(4'h4);
        check("statusWord", statusWord, 16'h0240);
        u_host.write_reg(`REG_QS_OPTION, {16'h0000, `QS_OPT_STAY}, rs);
        step(26, 30);
        pulse(4'h4);
        check("statusWord", statusWord, 16'h0217);
        step(30, 32);
        pulse(4'h8);
        check("motionAccept", motionAccept, 1'b1);
        @(posedge sys_clk);
        faultActive <= 1'b1;
        settle();
        check("statusWord", statusWord, 16'h021F);
        check("quickStopRun", quickStopRun, 1'b1);
        pulse(4'h2);
        check("statusWord", statusWord, 16'h0208);
        check("driveEnable", driveEnable, 1'b0);
        u_host.write_reg(`REG_CTRL_WORD, 32'h0000_0080, rs);
        settle();
        check("statusWord", statusWord, 16'h0208);
        faultActive <= 1'b0;
        u_host.write_reg(`REG_CTRL_WORD, 32'h0000_0000, rs);
        u_host.write_reg(`REG_CTRL_WORD, 32'h0000_0080, rs);
        settle();
        check("statusWord", statusWord, 16'h0240);
        u_host.write_reg(`REG_CTRL_WORD, 32'h0000_0000, rs);
        u_host.read_reg(`REG_STATE, rd, rs);
        check("stateReg", rd, 32'h0000_0001);
        check("rresp", rs, `RESP_OKAY);
        report_and_stop();
    end
endmodule
`default_nettype wire
